// >>> verilog/timer_unit_cfg.svh
// offsets, field positions, reset values and counts of the timer unit
// assumes 32-bit word-addressed register bus, one clock
// Function
// RULE1: set channel flag on match or capture
// RULE2: flag rises cycle after its event; code sets it two cycles after the event
// RULE3: interrupt when flag set and enabled
// RULE4: write one clears channel flag
// RULE5: capture mode: reading value clears flag
// RULE6: capture while flag set raises error
// RULE7: write one clears error flag
// RULE8: write one sets error enable
// RULE9: write one sets overflow enable
// RULE10: flag register layout and zero reset
// RULE11: counter width 8, 16 or 32
// RULE12: two channels, buffered compare, period
// RULE13: interrupts and events on wrap, match
// RULE14: count input events or prescaled clock
// RULE15: wrap flag on overflow, write one clears
`ifndef TIMER_UNIT_CFG_SVH
`define TIMER_UNIT_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL        6'h00
`define IDX_IRQ_EN_CLR  6'h08
`define IDX_IRQ_EN_SET  6'h09
`define IDX_IRQ_FLAG    6'h0a
`define IDX_COUNT       6'h14
`define IDX_PERIOD      6'h1b
`define IDX_CC0         6'h1c
`define IDX_CC1         6'h1d

// ----------------------------------------------------------------
// flag and enable bit positions
// ----------------------------------------------------------------
`define BIT_WRAP        0
`define BIT_ERR         1
`define BIT_MC0         4
`define NUM_CHAN        2

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_RUN        0
`define CTRL_MODE_LO    1
`define CTRL_EVCOUNT    3
`define CTRL_PRE_LO     4
`define CTRL_DOWN       7
`define CTRL_CAP_LO     8

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define RST_FLAGS       8'h00
`define RST_ENABLES     8'h00
`define RST_CTRL        10'h000
`define RST_PERIOD      8'hff
`define PRE_W           10

`endif

// >>> verilog/timer_unit_pkg.sv
// types shared by the timer unit and its channels
// assumes nothing of its surroundings
`default_nettype none
package timer_unit_pkg;
    typedef enum logic [1:0] {
        width16,
        width8,
        width32
    } width_mode_t;

    typedef enum logic {
        bus_idle,
        bus_ack
    } bus_state_t;

    typedef logic [31:0] word_t;
endpackage : timer_unit_pkg
`default_nettype wire

// >>> verilog/chan_if.sv
// signals between the timer core and one compare/capture channel
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
interface chan_if (
    input wire logic clk,
    input wire logic rst
);
    logic [31:0] count;
    logic [31:0] wmask;
    logic        tick;
    logic        upd;
    logic        cap_mode;
    logic        cap_evt;
    logic        flag;
    logic        wr_cc;
    logic [31:0] wdata;
    logic        hit;
    logic        err;
    logic [31:0] rd_value;

    modport core (
        input  clk, rst, hit, err, rd_value,
        output count, wmask, tick, upd, cap_mode, cap_evt, flag, wr_cc, wdata
    );
    modport chan (
        input  clk, rst, count, wmask, tick, upd, cap_mode, cap_evt, flag, wr_cc, wdata,
        output hit, err, rd_value
    );
endinterface : chan_if
`default_nettype wire

// >>> verilog/cc_channel.sv
// one compare/capture channel with buffered compare value
// assumes core provides count, tick and update strobes
`timescale 1ns/1ns
`default_nettype none
module cc_channel (
    chan_if.chan ch
);
    import timer_unit_pkg::*;

    logic [31:0] cc_q;
    logic [31:0] cc_d;
    logic [31:0] buf_q;
    logic [31:0] buf_d;
    logic        bufv_q;
    logic        bufv_d;
    logic        hit_q;
    logic        err_q;
    wire         match_w;
    wire         cap_w;
    wire         store_w;
    wire         lost_w;

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    assign match_w = ~ch.cap_mode & ch.tick & (ch.count == (cc_q & ch.wmask)); // [RULE1]
    assign cap_w   = ch.cap_mode & ch.cap_evt;
    assign store_w = cap_w & ~ch.flag;                                          // [RULE1]
    assign lost_w  = cap_w & ch.flag;                                           // [RULE6]

    // ----------------------------------------------------------------
    // value and buffer
    // ----------------------------------------------------------------
    always_comb begin
        cc_d   = cc_q;
        buf_d  = buf_q;
        bufv_d = bufv_q;
        if (store_w) begin
            cc_d = ch.count;
        end else if (ch.wr_cc && ch.cap_mode) begin
            cc_d = ch.wdata & ch.wmask;
        end else if (ch.upd && bufv_q) begin
            cc_d   = buf_q;                                                    // [RULE12]
            bufv_d = 1'b0;
        end
        if (ch.wr_cc && !ch.cap_mode) begin
            buf_d  = ch.wdata & ch.wmask;                                      // [RULE12]
            bufv_d = 1'b1;
        end
    end

    always_ff @(posedge ch.clk) begin
        if (ch.rst) begin
            cc_q   <= 32'h0000_0000;
            buf_q  <= 32'h0000_0000;
            bufv_q <= 1'b0;
            hit_q  <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            cc_q   <= cc_d;
            buf_q  <= buf_d;
            bufv_q <= bufv_d;
            hit_q  <= match_w | store_w;
            err_q  <= lost_w;
        end
    end

    assign ch.hit      = hit_q;
    assign ch.err      = err_q;
    assign ch.rd_value = cc_q & ch.wmask;                                      // [RULE11]
endmodule : cc_channel
`default_nettype wire

// >>> verilog/timer_unit.sv
// timer unit: counter, prescaler, flags and enables behind an avalon-mm slave
// assumes word addresses on avs_address and a single clock ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "timer_unit_cfg.svh"
module timer_unit (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [3:0]          avs_byteenable,
    input  wire timer_unit_pkg::word_t avs_writedata,
    output var  timer_unit_pkg::word_t avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                count_event,
    input  wire logic [1:0]          capture_event,
    output logic                     irq,
    output logic                     wrap_event,
    output logic [1:0]               match_event
);
    import timer_unit_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] width_mask(input logic [1:0] mode);
        if (mode == width8) begin
            width_mask = 32'h0000_00ff;
        end else if (mode == width32) begin
            width_mask = 32'hffff_ffff;
        end else begin
            width_mask = 32'h0000_ffff;
        end
    endfunction : width_mask

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bus_state_t             bus_q;
    bus_state_t             bus_d;
    word_t                  rdata_q;
    word_t                  rdata_d;
    logic [9:0]             ctrl_q;
    logic [9:0]             ctrl_d;
    logic [7:0]             flags_q;
    logic [7:0]             flags_d;
    logic [7:0]             en_q;
    logic [7:0]             en_d;
    logic [31:0]            count_q;
    logic [31:0]            count_d;
    logic [7:0]             per_q;
    logic [7:0]             per_d;
    logic [7:0]             perbuf_q;
    logic [7:0]             perbuf_d;
    logic                   perv_q;
    logic                   perv_d;
    logic [`PRE_W-1:0]      pre_q;
    logic                   wrap_q;
    logic [1:0]             match_q;

    chan_if ch [`NUM_CHAN] (.clk(ref_clk), .rst(sys_rst));

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire         req_w    = avs_read | avs_write;
    wire         take_w   = req_w & (bus_q == bus_ack);
    wire         wr_w     = avs_write & take_w;
    wire         rd_w     = avs_read & take_w;
    wire [31:0]  bem_w    = lane_mask(avs_byteenable);
    wire [31:0]  wd_w     = avs_writedata & bem_w;
    wire         sel_ctrl = avs_address == `IDX_CTRL;
    wire         sel_eclr = avs_address == `IDX_IRQ_EN_CLR;
    wire         sel_eset = avs_address == `IDX_IRQ_EN_SET;
    wire         sel_flag = avs_address == `IDX_IRQ_FLAG;
    wire         sel_cnt  = avs_address == `IDX_COUNT;
    wire         sel_per  = avs_address == `IDX_PERIOD;
    wire         sel_cc0  = avs_address == `IDX_CC0;
    wire         sel_cc1  = avs_address == `IDX_CC1;

    assign avs_waitrequest = req_w & (bus_q == bus_idle);
    assign avs_readdata    = rdata_q;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    wire [1:0]   mode_w   = ctrl_q[`CTRL_MODE_LO +: 2];
    wire         run_w    = ctrl_q[`CTRL_RUN];
    wire         evcnt_w  = ctrl_q[`CTRL_EVCOUNT];
    wire [2:0]   pre_sel  = ctrl_q[`CTRL_PRE_LO +: 3];
    wire         down_w   = ctrl_q[`CTRL_DOWN];
    wire [1:0]   cap_w    = ctrl_q[`CTRL_CAP_LO +: 2];
    wire [31:0]  wmask_w  = width_mask(mode_w);                                  // [RULE11]
    wire [31:0]  top_w    = (mode_w == width8) ? {24'h000000, per_q} : wmask_w;

    // ----------------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------------
    wire [`PRE_W-1:0] pre_mask = `PRE_W'((`PRE_W'(1) << pre_sel) - `PRE_W'(1));
    wire         pre_tick = &(pre_q | ~pre_mask);
    wire         tick_w   = run_w & (evcnt_w ? count_event : pre_tick);         // [RULE14]
    wire         at_end_w = down_w ? (count_q == 32'h0000_0000) : (count_q == top_w);
    wire         wrap_w   = tick_w & at_end_w;                                   // [RULE15]

    always_comb begin
        count_d  = count_q;
        per_d    = per_q;
        perbuf_d = perbuf_q;
        perv_d   = perv_q;
        if (wr_w && sel_cnt) begin
            count_d = ((count_q & ~bem_w) | wd_w) & wmask_w;
        end else if (wrap_w) begin
            count_d = down_w ? top_w : 32'h0000_0000;                            // [RULE15]
        end else if (tick_w) begin
            count_d = (down_w ? count_q - 32'h0000_0001 : count_q + 32'h0000_0001) & wmask_w;
        end
        if (wrap_w && perv_q) begin
            per_d  = perbuf_q;                                                   // [RULE12]
            perv_d = 1'b0;
        end
        if (wr_w && sel_per && avs_byteenable[0]) begin
            if (mode_w == width8) begin
                perbuf_d = avs_writedata[7:0];                                   // [RULE12]
                perv_d   = 1'b1;
            end else begin
                per_d = avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    wire [1:0]   hit_w;
    wire [1:0]   err_w;
    wire [31:0]  ccv_w [`NUM_CHAN];

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CHAN; gi++) begin : g_chan
            assign ch[gi].count    = count_q;
            assign ch[gi].wmask    = wmask_w;
            assign ch[gi].tick     = tick_w;
            assign ch[gi].upd      = wrap_w;
            assign ch[gi].cap_mode = cap_w[gi];
            assign ch[gi].cap_evt  = capture_event[gi];
            assign ch[gi].flag     = flags_q[`BIT_MC0 + gi];
            assign ch[gi].wr_cc    = wr_w & (avs_address == (`IDX_CC0 + 6'(gi)));
            assign ch[gi].wdata    = avs_writedata;
            assign hit_w[gi]       = ch[gi].hit;
            assign err_w[gi]       = ch[gi].err;
            assign ccv_w[gi]       = ch[gi].rd_value;
            cc_channel u_chan (
                .ch (ch[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // flags and enables
    // ----------------------------------------------------------------
    wire [7:0]   flag_wr  = (wr_w && sel_flag) ? wd_w[7:0] : 8'h00;
    wire [1:0]   rd_clr   = {rd_w & sel_cc1 & cap_w[1], rd_w & sel_cc0 & cap_w[0]}; // [RULE5]
    wire [7:0]   set_w    = {2'b00, hit_w, 2'b00, |err_w, wrap_q};                 // [RULE1]
    wire [7:0]   clr_w    = (flag_wr | {2'b00, rd_clr, 4'h0}) & 8'h33;             // [RULE4]
    wire [7:0]   eset_w   = (wr_w && sel_eset) ? wd_w[7:0] & 8'h33 : 8'h00;
    wire [7:0]   eclr_w   = (wr_w && sel_eclr) ? wd_w[7:0] & 8'h33 : 8'h00;

    always_comb begin
        flags_d = (flags_q & ~clr_w) | set_w;                                    // [RULE2] [RULE7]
        en_d    = (en_q & ~eclr_w) | eset_w;                                     // [RULE8] [RULE9]
        ctrl_d  = ctrl_q;
        if (wr_w && sel_ctrl) begin
            ctrl_d = (ctrl_q & ~bem_w[9:0]) | wd_w[9:0];
            if (ctrl_d[`CTRL_MODE_LO +: 2] == 2'b11) begin
                ctrl_d[`CTRL_MODE_LO +: 2] = width16;
            end
        end
    end

    assign irq         = |(flags_q & en_q);                                      // [RULE3] [RULE13]
    assign wrap_event  = wrap_q;                                                 // [RULE13]
    assign match_event = match_q;                                                // [RULE13]

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (avs_read && bus_q == bus_idle) begin
            if (sel_ctrl) begin
                rdata_d = {22'h0, ctrl_q};
            end else if (sel_eclr || sel_eset) begin
                rdata_d = {24'h000000, en_q};
            end else if (sel_flag) begin
                rdata_d = {24'h000000, flags_q};                                 // [RULE10]
            end else if (sel_cnt) begin
                rdata_d = count_q;
            end else if (sel_per) begin
                rdata_d = {24'h000000, per_q};
            end else if (sel_cc0) begin
                rdata_d = ccv_w[0];
            end else if (sel_cc1) begin
                rdata_d = ccv_w[1];
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_comb begin
        bus_d = bus_idle;
        case (bus_q)
            bus_idle: begin
                if (req_w) begin
                    bus_d = bus_ack;
                end
            end
            bus_ack: begin
                bus_d = bus_idle;
            end
            default: begin
                bus_d = bus_idle;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_q   <= bus_idle;
            rdata_q <= 32'h0000_0000;
            ctrl_q  <= `RST_CTRL;
            flags_q <= `RST_FLAGS;                                               // [RULE10]
            en_q    <= `RST_ENABLES;
        end else begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
            flags_q <= flags_d;
            en_q    <= en_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_q  <= 32'h0000_0000;
            per_q    <= `RST_PERIOD;
            perbuf_q <= `RST_PERIOD;
            perv_q   <= 1'b0;
            pre_q    <= `PRE_W'(0);
            wrap_q   <= 1'b0;
            match_q  <= 2'b00;
        end else begin
            count_q  <= count_d;
            per_q    <= per_d;
            perbuf_q <= perbuf_d;
            perv_q   <= perv_d;
            pre_q    <= run_w ? pre_q + `PRE_W'(1) : `PRE_W'(0);
            wrap_q   <= wrap_w;
            match_q  <= hit_w;
        end
    end
endmodule : timer_unit
`default_nettype wire

// >>> testbench/timer_unit_props.sv
// checker of the timer unit: bus handshake, events, irq
// assumes it is bound onto timer_unit, one clock ref_clk
`timescale 1ns/1ns
`default_nettype none
module timer_unit_props (
    input wire logic                  ref_clk,
    input wire logic                  sys_rst,
    input wire logic [5:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [3:0]            avs_byteenable,
    input wire timer_unit_pkg::word_t avs_writedata,
    input wire timer_unit_pkg::word_t avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic                  count_event,
    input wire logic [1:0]            capture_event,
    input wire logic                  irq,
    input wire logic                  wrap_event,
    input wire logic [1:0]            match_event
);
    import timer_unit_pkg::*;
    // ------------------------------------------------------------
    // shadow of the enables
    // ------------------------------------------------------------
    logic [7:0] en_q;
    logic [7:0] en_d;
    wire        req   = avs_read | avs_write;
    wire        wr_lo = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign en_d = (wr_lo && avs_address == 6'h09) ? en_q | (avs_writedata[7:0] & 8'h33)
                : (wr_lo && avs_address == 6'h08) ? en_q & ~avs_writedata[7:0] : en_q;
    always_ff @(posedge ref_clk) begin
        en_q <= sys_rst ? 8'h00 : en_d;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wait;
        req && avs_waitrequest;
    endsequence
    sequence s_rd_at(logic [5:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_wait_one_cycle: assert property (s_wait |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_idle_no_wait: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without a request");
    a_flag_layout: assert property (s_rd_at(6'h0a) |-> (avs_readdata & ~32'h33) == 0)
        else $error("flag register shows undefined bits");
    a_enset_readback: assert property (s_rd_at(6'h09) |->
        (avs_readdata[7:0] & 8'h33) == en_q)
        else $error("enables differ from set history");
    a_irq_needs_en: assert property (en_q == 8'h00 |-> !irq)
        else $error("irq with all enables off");
    a_wrap_sets_irq: assert property (wrap_event |=> (irq || !en_q[0]))
        else $error("wrap flag did not raise irq");
    a_match0_irq: assert property (match_event[0] |-> ##[1:2] (irq || !en_q[4]))
        else $error("channel 0 flag did not raise irq");
    a_match1_irq: assert property (match_event[1] |-> ##[1:2] (irq || !en_q[5]))
        else $error("channel 1 flag did not raise irq");
    a_wrap_pulse: assert property ($rose(wrap_event) |=> !wrap_event)
        else $error("wrap event longer than one cycle");
endmodule : timer_unit_props
`default_nettype wire

// >>> testbench/timer_unit_tb_top.sv
// self-checking bench of the timer unit flags and enables
// assumes timer_unit and its package, checker bound below
`timescale 1ns/1ns
`default_nettype none
module timer_unit_tb_top;
    import timer_unit_pkg::*;
    logic       ref_clk;
    logic       sys_rst;
    logic [5:0] avs_address;
    logic       avs_read;
    logic       avs_write;
    logic [3:0] avs_byteenable;
    word_t      avs_writedata;
    word_t      avs_readdata;
    logic       avs_waitrequest;
    logic       count_event;
    logic [1:0] capture_event;
    logic       irq;
    logic       wrap_event;
    logic [1:0] match_event;
    int         err_count;
    int         checks_done;
    word_t      rd;
    word_t      w;
    logic [7:0] en;

    timer_unit i_timer_unit (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .count_event(count_event),
        .capture_event(capture_event), .irq(irq), .wrap_event(wrap_event),
        .match_event(match_event)
    );

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic summarize();
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic chk_word(input word_t got, input word_t exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic bus(input logic wr, input logic [5:0] a, input word_t d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [5:0] a, input word_t m, input word_t exp);
        bus(1'b0, a, 32'h0);
        chk_word(rd & m, exp);
    endtask : rd_chk

    task automatic pulse(input logic [2:0] v);
        @(posedge ref_clk);
        {count_event, capture_event} <= v;
        @(posedge ref_clk);
        {count_event, capture_event} <= 3'b000;
        repeat (4) @(posedge ref_clk);
    endtask : pulse

    function automatic logic [7:0] exp_en(input logic [7:0] old, input logic [7:0] wv);
        return old | (wv & 8'h33);
    endfunction : exp_en

    function automatic logic exp_irq(input logic [7:0] f, input logic [7:0] e);
        return |(f & e);
    endfunction : exp_irq

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        summarize();
    end

    initial begin
        {avs_address, avs_read, avs_write, count_event, capture_event} = '0;
        avs_byteenable = 4'hf;
        avs_writedata  = 32'h0;
        sys_rst        = 1'b1;
        err_count      = 0;
        checks_done    = 0;
        en             = 8'h00;
        void'($urandom(32'h72ca));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk(6'h0a, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            bus(1'b1, 6'h09, w);
            en = exp_en(en, w[7:0]);
            rd_chk(6'h09, 32'h33, {24'h0, en});
        end
        // wrap by counted input events, enable off, channels in capture mode
        bus(1'b1, 6'h08, 32'h01);
        en[0] = 1'b0;
        bus(1'b1, 6'h1b, 32'h03);
        bus(1'b1, 6'h00, 32'h30b);
        repeat (3) pulse(3'b100);
        rd_chk(6'h0a, 32'hff, 32'h00);
        pulse(3'b100);
        rd_chk(6'h0a, 32'hff, 32'h01);
        @(negedge ref_clk);
        chk_bit(irq, exp_irq(8'h01, en));
        bus(1'b1, 6'h09, 32'h01);
        en[0] = 1'b1;
        @(negedge ref_clk);
        chk_bit(irq, exp_irq(8'h01, en));
        bus(1'b1, 6'h00, 32'h000);
        bus(1'b1, 6'h0a, 32'h00);
        rd_chk(6'h0a, 32'hff, 32'h01);
        bus(1'b1, 6'h0a, 32'h01);
        rd_chk(6'h0a, 32'hff, 32'h00);
        // captures on channel 0, lost capture, auto clear
        bus(1'b1, 6'h00, 32'h301);
        pulse(3'b001);
        rd_chk(6'h0a, 32'hff, 32'h10);
        pulse(3'b001);
        rd_chk(6'h0a, 32'hff, 32'h12);
        bus(1'b0, 6'h1c, 32'h0);
        rd_chk(6'h0a, 32'hff, 32'h02);
        bus(1'b1, 6'h0a, 32'h00);
        rd_chk(6'h0a, 32'hff, 32'h02);
        bus(1'b1, 6'h0a, 32'h02);
        rd_chk(6'h0a, 32'hff, 32'h00);
        // capture on channel 1, clear by wrong and right bit
        bus(1'b1, 6'h00, 32'h201);
        pulse(3'b010);
        rd_chk(6'h0a, 32'hff, 32'h20);
        @(negedge ref_clk);
        chk_bit(irq, exp_irq(8'h20, en));
        bus(1'b1, 6'h0a, 32'h10);
        rd_chk(6'h0a, 32'hff, 32'h20);
        bus(1'b1, 6'h0a, 32'h20);
        rd_chk(6'h0a, 32'hff, 32'h00);
        // buffered compare on channel 1 in 8-bit mode
        bus(1'b1, 6'h00, 32'h000);
        bus(1'b1, 6'h14, 32'h0);
        bus(1'b1, 6'h1d, 32'h02);
        bus(1'b1, 6'h00, 32'h003);
        repeat (16) @(posedge ref_clk);
        bus(1'b1, 6'h00, 32'h000);
        rd_chk(6'h0a, 32'h21, 32'h21);
        // down count wrap reloads top, mode 3 and 32-bit width
        bus(1'b1, 6'h0a, 32'h33);
        bus(1'b1, 6'h14, 32'h0);
        bus(1'b1, 6'h00, 32'h08b);
        pulse(3'b100);
        rd_chk(6'h0a, 32'h01, 32'h01);
        rd_chk(6'h14, 32'hffffffff, 32'h03);
        bus(1'b1, 6'h00, 32'h006);
        rd_chk(6'h00, 32'h3ff, 32'h000);
        bus(1'b1, 6'h00, 32'h004);
        bus(1'b1, 6'h14, 32'hffffffff);
        rd_chk(6'h14, 32'hffffffff, 32'hffffffff);
        rd_chk(6'h01 + 6'($urandom % 7), 32'hffffffff, 32'h0);
        summarize();
    end
endmodule : timer_unit_tb_top

bind timer_unit timer_unit_props i_timer_unit_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .count_event(count_event),
    .capture_event(capture_event), .irq(irq), .wrap_event(wrap_event),
    .match_event(match_event)
);
`default_nettype wire
